// [hw/pdsr_pkg.sv]
// shared constants for the discharge, power-good delay and sleep register slice
package pdsr_pkg;
  // register offsets on the byte register port
  localparam logic [7:0] PDSR_OFF_DISCHARGE_CTRL_THIRD = 8'h42;
  localparam logic [7:0] PDSR_OFF_POWER_GOOD_DELAY_FIRST = 8'h43;
  localparam logic [7:0] PDSR_OFF_EMERGENCY_SHUTDOWN_REQUEST = 8'h91;
  localparam logic [7:0] PDSR_OFF_FIRST_BUCK_SLEEP_CTRL = 8'h92;
  // field positions
  localparam int PDSR_SW2_LSB = 4; // second load switch discharge field
  localparam int PDSR_SW1_LSB = 2; // first load switch discharge field
  localparam int PDSR_LDO_LSB = 0; // third aux ldo discharge field
  localparam int PDSR_PGD_LSB = 0; // delay code, three bits
  localparam int PDSR_SHUTDOWN_REQUEST_BIT_BIT = 0; // shutdown request bit
  localparam int PDSR_SLP_EN_BIT = 0; // sleep enable bit
  localparam int PDSR_SLP_VID_LSB = 1; // sleep voltage code, seven bits
  // reset values before the factory load
  localparam logic [7:0] PDSR_RST_BYTE = 8'h00;
  localparam logic [1:0] PDSR_DISCH_NONE = 2'h0;
  // discharge codes
  localparam logic [1:0] PDSR_DISCH_100 = 2'h1;
  localparam logic [1:0] PDSR_DISCH_200 = 2'h2;
  localparam logic [1:0] PDSR_DISCH_500 = 2'h3;
  // timing: 10 MHz clock, 100 us delay tick
  localparam int PDSR_CLK_HZ = 10_000_000;
  localparam int PDSR_TICK_US = 100;
  localparam int PDSR_TICK_CYC = PDSR_CLK_HZ / 1_000_000 * PDSR_TICK_US;
  // power-good delays in microseconds, code 000 to 111
  localparam int PDSR_DLY_US [8] = '{2500, 5000, 10000, 15000, 20000, 50000, 75000, 100000};

  // delay code to a count of 100 us ticks
  function automatic logic [9:0] pdsr_dly_ticks(input logic [2:0] code);
    pdsr_dly_ticks = 10'(PDSR_DLY_US[code] / PDSR_TICK_US);
  endfunction : pdsr_dly_ticks

  // discharge code to one-hot resistor select {500, 200, 100}
  function automatic logic [2:0] pdsr_disch_onehot(input logic [1:0] code);
    pdsr_disch_onehot = {code == PDSR_DISCH_500, code == PDSR_DISCH_200,
                         code == PDSR_DISCH_100};
  endfunction : pdsr_disch_onehot
endpackage : pdsr_pkg

// [hw/pdsr_pg_delay.sv]
// power-good delay timer for the third general output
`timescale 1ns/1ps
module pdsr_pg_delay
  import pdsr_pkg::*;
#(
  parameter int TICK_CYC = PDSR_TICK_CYC // clock cycles per 100 us tick
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic soft_clr, // emergency shutdown clear
  input wire logic active, // delay path in use
  input wire logic rails_ok, // all grouped rails in regulation
  input wire logic [2:0] delay_code, // programmed delay code
  output logic pg_good // delayed power good
);
  typedef enum logic [2:0] {
    PG_IDLE = 3'b001,
    PG_WAIT = 3'b010,
    PG_GOOD = 3'b100
  } pdsr_pg_state_t;

  pdsr_pg_state_t state_q, state_d; // timer state
  logic [15:0] div_q; // tick divider
  logic [9:0] ticks_q; // ticks elapsed in wait
  logic [9:0] target_q; // ticks latched at start
  wire start = (state_q == PG_IDLE) && rails_ok && active; // rails just settled
  wire tick = (div_q == 16'(TICK_CYC - 1)); // one-cycle enable
  wire done = tick && (ticks_q + 10'h001 == target_q); // last tick reached

  // next state; losing any rail or the path drops power good at once
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PG_IDLE: if (start) state_d = PG_WAIT;
      PG_WAIT: if (done) state_d = PG_GOOD;
      PG_GOOD: state_d = PG_GOOD;
    endcase
    if (!rails_ok || !active || soft_clr) begin
      state_d = PG_IDLE;
    end
  end

  // divider restarts at the start so the delay is whole ticks, not tick minus phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PG_IDLE;
      div_q <= 16'h0000;
      ticks_q <= 10'h000;
      target_q <= 10'h000;
    end else begin
      state_q <= state_d;
      div_q <= (start || tick) ? 16'h0000 : div_q + 16'h0001;
      if (start) begin
        ticks_q <= 10'h000;
        target_q <= pdsr_dly_ticks(delay_code);
      end else if (tick && state_q == PG_WAIT) begin
        ticks_q <= ticks_q + 10'h001;
      end
    end
  end

  assign pg_good = (state_q == PG_GOOD);

  // power good only rises when the last programmed tick ends
  a_pg_after_delay: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(pg_good) |-> $past(ticks_q) + 10'h001 == target_q)
    else $error("power good rose before the programmed delay");
  // losing regulation drops power good on the next edge
  a_pg_drops_fast: assert property (@(posedge clk) disable iff (!reset_n)
    !rails_ok |=> !pg_good)
    else $error("power good held without regulation");
  c_pg_reached: cover property (@(posedge clk) disable iff (!reset_n) $rose(pg_good));
endmodule : pdsr_pg_delay

// [hw/pdsr_regs.sv]
// register slice: rail discharge, power-good delay, emergency shutdown, buck sleep
//
// Functional notes
// - enabled rail forces its discharge field to 00
// - 42h holds switch two, switch one, ldo fields
// - discharge codes: none, 100, 200, 500 ohms
// - 43h holds three-bit delay code, rest reserved
// - delay starts once grouped rails in regulation
// - codes select 2.5 ms up to 100 ms
// - host-driven output ignores the delay code; with output_vtt_use set the pin still follows the delayed power good
// - 91h resets zero, only bit 0 writable
// - writing one starts emergency shutdown and reset
// - shutdown bit clears itself, reads back zero
// - shutdown data byte is not acknowledged
// - 92h holds sleep code 7:1, enable 0
// - sleep code sets buck target in sleep
// - sleep enable picks sleep code when pin low
// - sleep pin fixed by factory, not writable
`timescale 1ns/1ps
module pdsr_regs
  import pdsr_pkg::*;
#(
  parameter int TICK_CYC = PDSR_TICK_CYC // cycles per 100 us tick, shorten in simulation
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic reset_n, // async reset, active low
  // byte register port from the serial bus engine
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data byte
  output logic [7:0] reg_rdata, // read data, one cycle after strobe
  output logic reg_ack, // acknowledge for the data byte
  // rail enables
  input wire logic third_aux_ldo_en, // third aux ldo enabled
  input wire logic first_load_switch_en, // first load switch enabled
  input wire logic second_load_switch_en, // second load switch enabled
  // discharge control to the rails
  output logic [1:0] third_aux_ldo_discharge_sel, // effective code
  output logic [1:0] first_switch_discharge_sel, // effective code
  output logic [1:0] second_switch_discharge_sel, // effective code
  output logic [2:0] third_aux_ldo_res, // one-hot {500,200,100}
  output logic [2:0] first_switch_res, // one-hot {500,200,100}
  output logic [2:0] second_switch_res, // one-hot {500,200,100}
  // third general output
  input wire logic group_rails_ok, // grouped rails in regulation
  input wire logic output_host_ctrl, // pin driven by host command
  input wire logic output_vtt_use, // pin also enables termination ldo
  input wire logic output_host_level, // host-commanded level
  output logic third_general_output, // pin level
  // shutdown
  output logic emergency_shutdown, // one-cycle shutdown pulse
  // first buck sleep
  input wire logic third_control_sleep_input, // sleep pin option a, low active
  input wire logic sixth_control_sleep_input, // sleep pin option b, low active
  input wire logic [6:0] first_buck_voltage_code, // normal voltage code
  output logic [6:0] first_buck_target_code, // code in force
  output logic first_buck_in_sleep, // sleep code in force
  // factory configuration
  input wire logic [5:0] otp_discharge, // discharge fields, 5:0
  input wire logic [2:0] otp_pg_delay, // delay code
  input wire logic [7:0] otp_sleep_ctrl, // sleep control byte
  input wire logic otp_sleep_pin_sel // 0 third input, 1 sixth input
);
  // stored registers
  logic [5:0] disch_q, disch_d; // discharge fields, bits 5:0
  logic [2:0] pgd_q, pgd_d; // delay code
  logic [7:0] slp_q, slp_d; // sleep control byte
  logic shutdown_request_bit_q; // shutdown request, self-clearing
  logic load_q; // factory load pending
  logic pin_sel_q; // latched sleep pin choice
  logic [7:0] rdata_q; // read data register
  logic [1:0] ldo_sel_q, sw1_sel_q, sw2_sel_q; // effective discharge codes
  logic [2:0] ldo_res_q, sw1_res_q, sw2_res_q; // resistor selects
  logic out_q; // third output level
  logic [6:0] target_q; // buck target code
  logic in_sleep_q; // buck in sleep
  logic pg_good; // delayed power good

  // address decode
  wire hit_disch = (reg_addr == PDSR_OFF_DISCHARGE_CTRL_THIRD);
  wire hit_pgd = (reg_addr == PDSR_OFF_POWER_GOOD_DELAY_FIRST);
  wire hit_shutdown_request_bit = (reg_addr == PDSR_OFF_EMERGENCY_SHUTDOWN_REQUEST);
  wire hit_slp = (reg_addr == PDSR_OFF_FIRST_BUCK_SLEEP_CTRL);
  // writes are refused while the factory load runs
  wire wr_ok = reg_wr && !load_q;
  wire shutdown_request_bit_wr = wr_ok && hit_shutdown_request_bit && reg_wdata[PDSR_SHUTDOWN_REQUEST_BIT_BIT];
  // rail enable mask over the discharge fields
  wire [5:0] en_mask = {{2{second_load_switch_en}}, {2{first_load_switch_en}},
                        {2{third_aux_ldo_en}}};

  // data byte acknowledged unless it trips shutdown or the load is running
  assign reg_ack = !load_q && !shutdown_request_bit_wr;

  // read mux; reserved bits read as zero
  wire [7:0] rd_mux = hit_disch ? {2'b00, disch_q} :
                      hit_pgd ? {5'b00000, pgd_q} :
                      hit_shutdown_request_bit ? {7'h00, shutdown_request_bit_q} :
                      hit_slp ? slp_q :
                      PDSR_RST_BYTE;

  // next discharge fields: write only the writable bits, then clear enabled rails
  always_comb begin
    disch_d = disch_q;
    if (load_q) begin
      disch_d = otp_discharge;
    end else if (wr_ok && hit_disch) begin
      disch_d = reg_wdata[5:0];
    end
    disch_d = disch_d & ~en_mask;
  end

  // next delay code
  always_comb begin
    pgd_d = pgd_q;
    if (load_q) begin
      pgd_d = otp_pg_delay;
    end else if (wr_ok && hit_pgd) begin
      pgd_d = reg_wdata[PDSR_PGD_LSB +: 3];
    end
  end

  // next sleep control byte, all eight bits writable
  always_comb begin
    slp_d = slp_q;
    if (load_q) begin
      slp_d = otp_sleep_ctrl;
    end else if (wr_ok && hit_slp) begin
      slp_d = reg_wdata;
    end
  end

  // register storage; variant values arrive from the factory load, not the reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      disch_q <= 6'h00;
      pgd_q <= 3'h0;
      slp_q <= PDSR_RST_BYTE;
    end else begin
      disch_q <= disch_d;
      pgd_q <= pgd_d;
      slp_q <= slp_d;
    end
  end

  // shutdown bit lives one cycle then hands over to the reload
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_request_bit_q <= 1'b0;
      load_q <= 1'b1;
    end else begin
      shutdown_request_bit_q <= shutdown_request_bit_wr;
      load_q <= shutdown_request_bit_q;
    end
  end

  // sleep pin choice caught at each factory load, never by a write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sel_q <= 1'b0;
    end else if (load_q) begin
      pin_sel_q <= otp_sleep_pin_sel;
    end
  end

  // read data register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= PDSR_RST_BYTE;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // effective discharge codes; the mask acts at once, not a cycle after the store
  wire [5:0] disch_eff = disch_q & ~en_mask;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ldo_sel_q <= PDSR_DISCH_NONE;
      sw1_sel_q <= PDSR_DISCH_NONE;
      sw2_sel_q <= PDSR_DISCH_NONE;
      ldo_res_q <= 3'h0;
      sw1_res_q <= 3'h0;
      sw2_res_q <= 3'h0;
    end else begin
      ldo_sel_q <= disch_eff[PDSR_LDO_LSB +: 2];
      sw1_sel_q <= disch_eff[PDSR_SW1_LSB +: 2];
      sw2_sel_q <= disch_eff[PDSR_SW2_LSB +: 2];
      ldo_res_q <= pdsr_disch_onehot(disch_eff[PDSR_LDO_LSB +: 2]);
      sw1_res_q <= pdsr_disch_onehot(disch_eff[PDSR_SW1_LSB +: 2]);
      sw2_res_q <= pdsr_disch_onehot(disch_eff[PDSR_SW2_LSB +: 2]);
    end
  end

  // delay path used unless the host owns the pin and no termination ldo hangs on it
  wire host_only = output_host_ctrl && !output_vtt_use;

  // power-good delay timer
  pdsr_pg_delay #(
    .TICK_CYC(TICK_CYC)
  ) u_pg_delay (
    .clk(clk),
    .reset_n(reset_n),
    .soft_clr(shutdown_request_bit_q),
    .active(!host_only),
    .rails_ok(group_rails_ok),
    .delay_code(pgd_q),
    .pg_good(pg_good)
  );

  // output pin level: host level or delayed power good
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= host_only ? output_host_level : pg_good;
    end
  end

  // sleep selection; pin is low active, choice fixed at load
  wire sleep_pin_low = pin_sel_q ? !sixth_control_sleep_input
                                 : !third_control_sleep_input;
  wire use_sleep = slp_q[PDSR_SLP_EN_BIT] && sleep_pin_low;
  wire [6:0] slp_code = slp_q[PDSR_SLP_VID_LSB +: 7];

  // target code in force; step encoding is the converter's, passed through unchanged
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      target_q <= 7'h00;
      in_sleep_q <= 1'b0;
    end else begin
      target_q <= use_sleep ? slp_code : first_buck_voltage_code;
      in_sleep_q <= use_sleep;
    end
  end

  assign reg_rdata = rdata_q;
  assign third_aux_ldo_discharge_sel = ldo_sel_q;
  assign first_switch_discharge_sel = sw1_sel_q;
  assign second_switch_discharge_sel = sw2_sel_q;
  assign third_aux_ldo_res = ldo_res_q;
  assign first_switch_res = sw1_res_q;
  assign second_switch_res = sw2_res_q;
  assign third_general_output = out_q;
  assign emergency_shutdown = shutdown_request_bit_q;
  assign first_buck_target_code = target_q;
  assign first_buck_in_sleep = in_sleep_q;

  // third aux ldo and first switch, both enabled for two edges, show no discharge code, stored or effective
  a_disch_forced_off: assert property (@(posedge clk) disable iff (!reset_n)
    (third_aux_ldo_en && first_load_switch_en) [*2] |->
      ldo_sel_q == PDSR_DISCH_NONE && sw1_sel_q == PDSR_DISCH_NONE && disch_q[3:0] == 4'h0)
    else $error("discharge code present on an enabled rail");
  // second switch resistor select follows its 500 ohm code
  a_disch_decode: assert property (@(posedge clk) disable iff (!reset_n)
    sw2_sel_q == PDSR_DISCH_500 |-> sw2_res_q == 3'h4)
    else $error("500 ohm code did not select the 500 ohm resistor");
  // reserved bits of the delay register read zero
  a_pgd_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && hit_pgd |=> reg_rdata[7:3] == 5'h00 && reg_rdata[2:0] == $past(pgd_q))
    else $error("delay register read back wrong");
  // shutdown byte goes unacknowledged and fires one pulse then reload
  a_shutdown_request_bit_no_ack: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && hit_shutdown_request_bit && reg_wdata[0] && !load_q |-> !reg_ack ##1 emergency_shutdown)
    else $error("shutdown write acknowledged or not started");
  a_shutdown_request_bit_selfclear: assert property (@(posedge clk) disable iff (!reset_n)
    emergency_shutdown |=> !emergency_shutdown && load_q ##1 !load_q && pgd_q == $past(otp_pg_delay))
    else $error("shutdown bit stuck or registers not reloaded");
  // writing zero to the shutdown bit does nothing
  a_shutdown_request_bit_zero: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && hit_shutdown_request_bit && !reg_wdata[0] |=> !emergency_shutdown)
    else $error("zero write started a shutdown");
  // sleep disabled always gives the normal code
  a_sleep_off: assert property (@(posedge clk) disable iff (!reset_n)
    !slp_q[0] |=> first_buck_target_code == $past(first_buck_voltage_code))
    else $error("sleep code used with sleep disabled");
  a_sleep_on: assert property (@(posedge clk) disable iff (!reset_n)
    slp_q[0] && sleep_pin_low |=> first_buck_target_code == $past(slp_q[7:1]))
    else $error("sleep code not used with pin low");
  // host-driven pin follows the host level only
  a_host_output: assert property (@(posedge clk) disable iff (!reset_n)
    host_only |=> third_general_output == $past(output_host_level))
    else $error("delay path drove a host-owned pin");
  // reserved bits of the discharge and shutdown registers read zero
  a_disch_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && hit_disch |=> reg_rdata[7:6] == 2'h0)
    else $error("discharge register reserved bits read nonzero");
  a_shutdown_request_bit_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    reg_rd && hit_shutdown_request_bit |=> reg_rdata[7:1] == 7'h00)
    else $error("shutdown register reserved bits read nonzero");
  // an enabled second switch shows no code one edge later
  a_sw2_forced_off: assert property (@(posedge clk) disable iff (!reset_n)
    second_load_switch_en |=> sw2_sel_q == PDSR_DISCH_NONE && sw2_res_q == 3'h0)
    else $error("discharge code present on the enabled second switch");
  // nothing but the factory load moves the sleep pin choice
  a_pin_sel_fixed: assert property (@(posedge clk) disable iff (!reset_n)
    !load_q |=> pin_sel_q == $past(pin_sel_q))
    else $error("sleep pin choice changed outside the factory load");
  // the load cycle puts the factory values in place
  a_load_values: assert property (@(posedge clk) disable iff (!reset_n)
    load_q |=> pgd_q == $past(otp_pg_delay) && slp_q == $past(otp_sleep_ctrl))
    else $error("factory values not loaded");
  // an accepted sleep control write lands whole
  a_sleep_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ok && hit_slp |=> slp_q == $past(reg_wdata))
    else $error("sleep control write did not land");

  c_shutdown: cover property (@(posedge clk) disable iff (!reset_n) shutdown_request_bit_wr);
  c_sleep_entry: cover property (@(posedge clk) disable iff (!reset_n) $rose(in_sleep_q));
  c_disch_cleared: cover property (@(posedge clk) disable iff (!reset_n)
    disch_q[1:0] != 2'h0 ##1 disch_q[1:0] == 2'h0);
endmodule : pdsr_regs

// [testbench/pdsr_host_model.sv]
// host model on the byte register port, in place of the serial bus engine
`timescale 1ns/1ps
module pdsr_host_model (
  input wire logic clk, // system clock
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_addr, // register offset
  output logic [7:0] reg_wdata, // write byte
  input wire logic [7:0] reg_rdata, // read data
  input wire logic reg_ack // byte acknowledge
);
  // idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one byte write; ack is combinational and is taken at the edge that takes the byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    ack = reg_ack; // a missing ack after a shutdown byte is no bus fault here
    reg_wr <= 1'b0;
    // released lines change so a stale value cannot pass
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // one byte read; data lands at the taking edge and is sampled at the falling edge after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
endmodule : pdsr_host_model

// [testbench/testbench.sv]
// self-checking bench for the discharge, power-good delay and sleep register slice
`timescale 1ns/1ps
module testbench;
  import pdsr_pkg::*;
  localparam int TCK = 2; // short tick keeps the 100 ms case near 2000 cycles
  logic clk, reset_n, reg_wr, reg_rd, reg_ack, ldo_en, sw1_en, sw2_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, otp_slp;
  logic [1:0] ldo_sel, sw1_sel, sw2_sel;
  logic [2:0] ldo_res, sw1_res, sw2_res, otp_pgd;
  logic rails_ok, host_ctrl, vtt_use, host_lvl, gpo, shutdown_request_bit_pulse, pin3, pin6, in_sleep, pin_sel;
  logic [6:0] vcode, tcode;
  logic [5:0] otp_dis;
  int n_mismatch = 0; // failed comparisons
  int total_checks = 0; // all comparisons
  int dly_t [8] = '{25, 50, 100, 150, 200, 500, 750, 1000}; // delay in 100 us ticks

  pdsr_regs #(.TICK_CYC(TCK)) pdsr_regs_i (.clk(clk), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .third_aux_ldo_en(ldo_en),
    .first_load_switch_en(sw1_en), .second_load_switch_en(sw2_en),
    .third_aux_ldo_discharge_sel(ldo_sel), .first_switch_discharge_sel(sw1_sel),
    .second_switch_discharge_sel(sw2_sel), .third_aux_ldo_res(ldo_res),
    .first_switch_res(sw1_res), .second_switch_res(sw2_res), .group_rails_ok(rails_ok),
    .output_host_ctrl(host_ctrl), .output_vtt_use(vtt_use), .output_host_level(host_lvl),
    .third_general_output(gpo), .emergency_shutdown(shutdown_request_bit_pulse),
    .third_control_sleep_input(pin3), .sixth_control_sleep_input(pin6),
    .first_buck_voltage_code(vcode), .first_buck_target_code(tcode),
    .first_buck_in_sleep(in_sleep), .otp_discharge(otp_dis), .otp_pg_delay(otp_pgd),
    .otp_sleep_ctrl(otp_slp), .otp_sleep_pin_sel(pin_sel));
  pdsr_host_model pdsr_host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // one compare for every result, widened to a byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wrw(input logic [7:0] a, input logic [7:0] d, input logic ack_exp);
    logic ack;
    pdsr_host_model_i.wr(a, d, ack);
    chk({7'h00, ack}, {7'h00, ack_exp}, "write ack");
  endtask : wrw

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    pdsr_host_model_i.rd(a, d);
    chk(d, exp, "read back");
  endtask : rdc

  // let n edges pass, then look between edges
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // expected one-hot {500,200,100} for a discharge code
  function automatic logic [2:0] exp_res(input logic [1:0] c);
    exp_res = (c == 2'h0) ? 3'h0 : 3'(3'h1 << (c - 2'h1));
  endfunction : exp_res

  // factory values show after load; unmapped offset reads zero
  task automatic t_load();
    rdc(8'h42, {2'h0, otp_dis});
    rdc(8'h43, {5'h00, otp_pgd});
    rdc(8'h91, 8'h00);
    rdc(8'h92, otp_slp);
    wrw(8'h50, 8'hA5, 1'b1);
    rdc(8'h50, 8'h00);
  endtask : t_load

  // every code on every rail, then an enabled rail forces 00
  task automatic t_discharge();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wrw(8'h42, {2'h3, c, c, c}, 1'b1);
      rdc(8'h42, {2'h0, c, c, c});
      settle(2);
      chk({2'h0, sw2_sel, sw1_sel, ldo_sel}, {2'h0, c, c, c}, "sel codes");
      chk({2'h0, sw1_res, ldo_res}, {2'h0, exp_res(c), exp_res(c)}, "res ldo sw1");
      chk({5'h00, sw2_res}, {5'h00, exp_res(c)}, "res sw2");
    end
    @(posedge clk);
    sw2_en <= 1'b1;
    settle(3);
    chk({3'h0, sw2_sel, sw2_res}, 8'h00, "enabled rail");
    chk({2'h0, sw1_res, ldo_res}, 8'h24, "other rails kept");
    wrw(8'h42, 8'h3F, 1'b1);
    rdc(8'h42, 8'h0F);
    @(posedge clk);
    ldo_en <= 1'b1;
    sw1_en <= 1'b1;
    settle(2);
    chk({2'h0, sw2_sel, sw1_sel, ldo_sel}, 8'h00, "all enabled");
    rdc(8'h42, 8'h00);
    @(posedge clk);
    {ldo_en, sw1_en, sw2_en} <= 3'h0;
  endtask : t_discharge

  // each delay code, window around the programmed delay
  task automatic t_pg_delay();
    int n;
    for (int i = 0; i < 8; i++) begin
      wrw(8'h43, {5'h1F, 3'(i)}, 1'b1);
      rdc(8'h43, {5'h00, 3'(i)});
      @(posedge clk);
      rails_ok <= 1'b1;
      n = dly_t[i] * TCK + 2;
      settle(n - 1);
      chk({7'h00, gpo}, 8'h00, "pg early");
      settle(0);
      chk({7'h00, gpo}, 8'h01, "pg late");
      @(posedge clk);
      rails_ok <= 1'b0;
      settle(3);
      chk({7'h00, gpo}, 8'h00, "pg drop");
    end
  endtask : t_pg_delay

  // host-owned pin follows its level; with termination use the delay still holds
  task automatic t_host_pin();
    @(posedge clk);
    host_ctrl <= 1'b1;
    host_lvl <= 1'b1;
    settle(2);
    chk({7'h00, gpo}, 8'h01, "host high");
    @(posedge clk);
    host_lvl <= 1'b0;
    settle(2);
    chk({7'h00, gpo}, 8'h00, "host low");
    @(posedge clk);
    vtt_use <= 1'b1;
    host_lvl <= 1'b1;
    rails_ok <= 1'b1;
    settle(4);
    chk({7'h00, gpo}, 8'h00, "vtt delay");
    @(posedge clk);
    host_ctrl <= 1'b0;
    vtt_use <= 1'b0;
    rails_ok <= 1'b0;
  endtask : t_host_pin

  // reserved bits and a zero write do nothing; a one pulses once and reloads
  task automatic t_shutdown();
    int n;
    wrw(8'h91, 8'hFE, 1'b1);
    settle(0);
    chk({7'h00, shutdown_request_bit_pulse}, 8'h00, "no pulse");
    rdc(8'h91, 8'h00);
    wrw(8'h92, 8'h55, 1'b1);
    wrw(8'h43, 8'h01, 1'b1);
    wrw(8'h91, 8'h01, 1'b0);
    n = 0;
    repeat (6) begin
      @(negedge clk);
      if (shutdown_request_bit_pulse === 1'b1) n++;
    end
    chk(8'(n), 8'h01, "pulse width");
    settle(2);
    rdc(8'h91, 8'h00);
    rdc(8'h92, otp_slp);
    rdc(8'h43, {5'h00, otp_pgd});
  endtask : t_shutdown

  task automatic sleep_case(input logic p3, input logic p6, input logic [6:0] code);
    @(posedge clk);
    pin3 <= p3;
    pin6 <= p6;
    settle(2);
    chk({1'b0, tcode}, {1'b0, code}, "target code");
    chk({7'h00, in_sleep}, {7'h00, 1'(code != vcode)}, "in sleep");
  endtask : sleep_case

  // sleep code only with enable set and the factory-chosen pin low
  task automatic t_sleep();
    wrw(8'h92, 8'h55, 1'b1);
    rdc(8'h92, 8'h55);
    sleep_case(1'b1, 1'b1, vcode);
    sleep_case(1'b0, 1'b1, 7'h2A);
    sleep_case(1'b1, 1'b0, vcode);
    wrw(8'h92, 8'h54, 1'b1);
    sleep_case(1'b0, 1'b1, vcode);
    // other factory pin choice only takes hold at the reload after a shutdown
    @(posedge clk);
    pin_sel <= 1'b1;
    wrw(8'h91, 8'h01, 1'b0);
    settle(3);
    wrw(8'h92, 8'h55, 1'b1);
    sleep_case(1'b1, 1'b0, 7'h2A);
    sleep_case(1'b0, 1'b1, vcode);
  endtask : t_sleep

  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    reset_n = 1'b0;
    {ldo_en, sw1_en, sw2_en, rails_ok, host_ctrl, vtt_use, host_lvl} = 7'h00;
    {pin3, pin6, pin_sel} = 3'h6;
    vcode = 7'h11;
    otp_dis = 6'h15;
    otp_pgd = 3'h6;
    otp_slp = 8'hE8;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    settle(3);
    t_load();
    t_discharge();
    t_pg_delay();
    t_host_pin();
    t_shutdown();
    t_sleep();
    give_verdict();
  end
endmodule : testbench
